// ===== rtl/omc_osc_mode_ctrl.sv
// Purpose: oscillator select, operating mode and comparator control register
// Assumes: firmware obeys the stop-bit write ordering; comparator input synchronous
// Notes: one register plus an interrupt status and mask pair
// Operation
// RULE_01 - select bit picks high or low oscillator
// RULE_02 - stop bit halts the high oscillator
// RULE_03 - mode field: normal, halt, standby, reserved
// RULE_04 - enable bit gates comparator interrupt
// RULE_05 - comparator output change sets flag
// RULE_06 - flag held until firmware write clears
// RULE_07 - pad enable drives comparator onto pin
// RULE_08 - comparator beats buzzer on shared pin
// RULE_09 - result bit read-only, live comparator state
// RULE_10 - firmware never changes stop with select/mode
// RULE_11 - reset values: select one, rest zero
// RULE_12 - request only when flag and enable set
`timescale 1ns/100ps
module omc_osc_mode_ctrl (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [omc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [omc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [omc_pkg::DATA_W-1:0] reg_rdata,
    input wire logic cmp_in,
    input wire logic buzzer_en,
    input wire logic buzzer_out,
    input wire logic gpio_out,
    input wire logic gpio_out_en_n,
    output logic sys_osc_high_sel,
    output logic high_osc_stop,
    output logic high_osc_run,
    output logic [1:0] op_mode_sel,
    output logic mode_halt,
    output logic mode_standby,
    output logic cmp_irq_req,
    output logic port_b_bit3_pad_out,
    output logic port_b_bit3_pad_oe_n,
    output logic irq
);
    import omc_pkg::*;

    omc_ev_if ev ();

    logic high_sel_q;
    logic high_stop_q;
    omc_mode_t mode_q;
    logic cmp_ie_q;
    logic cmp_if_q;
    logic cmp_oe_q;
    logic cmp_q;
    logic cmp_seen_q;
    logic [1:0] mask_q;
    logic [DATA_W-1:0] rdata_d;
    logic wr_ctl;
    logic cmp_change;
    logic pad_d;
    logic pad_oe_n_d;

    assign wr_ctl = reg_wr && (reg_addr == OSC_MODE_CONTROL_OFS);

    // first sample only primes the edge detector, so reset is no change
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cmp_q <= 1'b0;
            cmp_seen_q <= 1'b0;
        end else begin
            cmp_q <= cmp_in;
            cmp_seen_q <= 1'b1;
        end
    end
    assign cmp_change = cmp_seen_q && (cmp_in != cmp_q); // RULE_05

    // control fields
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            high_sel_q <= RST_HIGH_SEL; // RULE_11
            high_stop_q <= RST_HIGH_STOP;
            mode_q <= omc_mode_t'(RST_MODE);
            cmp_ie_q <= RST_CMP_IE;
            cmp_oe_q <= RST_CMP_OE;
        end else if (wr_ctl) begin
            // stop bit ordering against select/mode is left to firmware
            high_sel_q <= reg_wdata[BIT_HIGH_SEL]; // RULE_01
            high_stop_q <= reg_wdata[BIT_HIGH_STOP]; // RULE_02
            mode_q <= omc_mode_t'(reg_wdata[BIT_MODE_HI:BIT_MODE_LO]); // RULE_03
            cmp_ie_q <= reg_wdata[BIT_CMP_IE]; // RULE_04
            cmp_oe_q <= reg_wdata[BIT_CMP_OE]; // RULE_07
        end
    end

    // flag only clears by an explicit write of zero; a change in that cycle wins
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cmp_if_q <= RST_CMP_IF;
        end else if (cmp_change) begin
            cmp_if_q <= 1'b1; // RULE_05
        end else if (wr_ctl) begin
            cmp_if_q <= reg_wdata[BIT_CMP_IF]; // RULE_06
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mask_q <= RST_IRQ;
        end else if (reg_wr && (reg_addr == IRQ_MASK_OFS)) begin
            mask_q <= reg_wdata[1:0];
        end
    end

    assign ev.cmp_change = cmp_change;
    assign ev.bad_mode = wr_ctl && (reg_wdata[BIT_MODE_HI:BIT_MODE_LO] == OMC_RESERVED);
    assign ev.status_rd = reg_rd && (reg_addr == IRQ_STATUS_OFS);

    omc_irq_status u_status (
        .mclk(mclk),
        .reset_n(reset_n),
        .ev(ev)
    );

    // read mux; result bit is the live input, never stored
    always_comb begin
        rdata_d = '0;
        unique case (reg_addr)
            OSC_MODE_CONTROL_OFS: begin
                rdata_d[BIT_CMP_RES] = cmp_in; // RULE_09
                rdata_d[BIT_CMP_OE] = cmp_oe_q;
                rdata_d[BIT_CMP_IF] = cmp_if_q;
                rdata_d[BIT_CMP_IE] = cmp_ie_q;
                rdata_d[BIT_MODE_HI:BIT_MODE_LO] = mode_q;
                rdata_d[BIT_HIGH_STOP] = high_stop_q;
                rdata_d[BIT_HIGH_SEL] = high_sel_q;
            end
            IRQ_STATUS_OFS: rdata_d[1:0] = ev.status;
            IRQ_MASK_OFS: rdata_d[1:0] = mask_q;
            default: rdata_d = '0;
        endcase
    end

    // pad: comparator first, then buzzer, else plain port
    always_comb begin
        if (cmp_oe_q) begin
            pad_d = cmp_in; // RULE_07
            pad_oe_n_d = 1'b0;
        end else if (buzzer_en) begin
            pad_d = buzzer_out; // RULE_08
            pad_oe_n_d = 1'b0;
        end else begin
            pad_d = gpio_out;
            pad_oe_n_d = gpio_out_en_n;
        end
    end

    // all outputs registered; one cycle behind the control state
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= '0;
            sys_osc_high_sel <= RST_HIGH_SEL;
            high_osc_stop <= RST_HIGH_STOP;
            high_osc_run <= ~RST_HIGH_STOP;
            op_mode_sel <= RST_MODE;
            mode_halt <= 1'b0;
            mode_standby <= 1'b0;
            cmp_irq_req <= 1'b0;
            port_b_bit3_pad_out <= 1'b0;
            port_b_bit3_pad_oe_n <= 1'b1;
            irq <= 1'b0;
        end else begin
            reg_rdata <= reg_rd ? rdata_d : '0;
            sys_osc_high_sel <= high_sel_q; // RULE_01
            high_osc_stop <= high_stop_q; // RULE_02
            high_osc_run <= ~high_stop_q; // RULE_02
            op_mode_sel <= mode_q;
            mode_halt <= (mode_q == OMC_HALT); // RULE_03
            mode_standby <= (mode_q == OMC_STANDBY); // RULE_03
            cmp_irq_req <= cmp_if_q && cmp_ie_q; // RULE_12
            port_b_bit3_pad_out <= pad_d;
            port_b_bit3_pad_oe_n <= pad_oe_n_d;
            irq <= |(ev.status & mask_q);
        end
    end
endmodule

// ===== rtl/omc_pkg.sv
// Purpose: constants and types for the oscillator and operating-mode control unit
// Assumes: 8-bit register port, one clock
// Notes: offsets are word indices on the plain register port
package omc_pkg;
    localparam int unsigned ADDR_W = 5;
    localparam int unsigned DATA_W = 8;
    localparam logic [ADDR_W-1:0] OSC_MODE_CONTROL_OFS = 5'h0f;
    localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 5'h1c;
    localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 5'h1d;
    localparam int unsigned BIT_HIGH_SEL = 0;
    localparam int unsigned BIT_HIGH_STOP = 1;
    localparam int unsigned BIT_MODE_LO = 2;
    localparam int unsigned BIT_MODE_HI = 3;
    localparam int unsigned BIT_CMP_IE = 4;
    localparam int unsigned BIT_CMP_IF = 5;
    localparam int unsigned BIT_CMP_OE = 6;
    localparam int unsigned BIT_CMP_RES = 7;
    localparam logic RST_HIGH_SEL = 1'b1;
    localparam logic RST_HIGH_STOP = 1'b0;
    localparam logic [1:0] RST_MODE = 2'h0;
    localparam logic RST_CMP_IE = 1'b0;
    localparam logic RST_CMP_IF = 1'b0;
    localparam logic RST_CMP_OE = 1'b0;
    localparam logic [1:0] RST_IRQ = 2'h0;
    // status/mask bits: 0 comparator change, 1 reserved mode code written
    localparam int unsigned EV_CMP = 0;
    localparam int unsigned EV_BADMODE = 1;
    typedef enum logic [1:0] {
        OMC_NORMAL = 2'h0,
        OMC_HALT = 2'h1,
        OMC_STANDBY = 2'h2,
        OMC_RESERVED = 2'h3
    } omc_mode_t;
endpackage

// ===== rtl/omc_ev_if.sv
// Purpose: event carrier between control core and status unit
// Assumes: one clock
// Notes: pulses are one cycle long
`timescale 1ns/100ps
interface omc_ev_if;
    logic cmp_change;
    logic bad_mode;
    logic status_rd;
    logic [1:0] status;
    modport src (output cmp_change, output bad_mode, output status_rd, input status);
    modport sink (input cmp_change, input bad_mode, input status_rd, output status);
endinterface

// ===== rtl/omc_irq_status.sv
// Purpose: sticky event status cleared by read
// Assumes: events and read are one-cycle pulses
// Notes: an event in the reading cycle survives the clear
`timescale 1ns/100ps
module omc_irq_status (
    input wire logic mclk,
    input wire logic reset_n,
    omc_ev_if.sink ev
);
    import omc_pkg::*;
    logic [1:0] status_q;
    logic [1:0] set_w;
    assign set_w = {ev.bad_mode, ev.cmp_change};
    assign ev.status = status_q;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            status_q <= RST_IRQ;
        end else begin
            // set wins over the read clear
            status_q <= set_w | (ev.status_rd ? 2'h0 : status_q);
        end
    end
endmodule

// ===== test/omc_properties.sv
// Purpose: port-level properties of the oscillator and mode control unit
// Assumes: outputs land two edges after the write that sets them
// Notes: pad check waits for a quiet comparator, since the pad is registered
`timescale 1ns/100ps
module omc_properties (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [omc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [omc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [omc_pkg::DATA_W-1:0] reg_rdata,
    input wire logic cmp_in,
    input wire logic sys_osc_high_sel,
    input wire logic high_osc_stop,
    input wire logic high_osc_run,
    input wire logic [1:0] op_mode_sel,
    input wire logic mode_halt,
    input wire logic mode_standby,
    input wire logic cmp_irq_req,
    input wire logic port_b_bit3_pad_out,
    input wire logic port_b_bit3_pad_oe_n
);
    import omc_pkg::*;
    logic wc;
    assign wc = reg_wr && reg_addr == OSC_MODE_CONTROL_OFS;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    osc_select_a: assert property (wc |->
        ##2 sys_osc_high_sel == $past(reg_wdata[0], 2)) else $error("select output wrong");
    osc_stop_a: assert property (wc |-> ##2 high_osc_stop == $past(reg_wdata[1], 2)
        && high_osc_run == !high_osc_stop) else $error("stop output wrong");
    mode_decode_a: assert property (wc |-> ##2 op_mode_sel == $past(reg_wdata[3:2], 2)
        && mode_halt == (op_mode_sel == OMC_HALT) && mode_standby == (op_mode_sel == OMC_STANDBY))
        else $error("mode outputs wrong");
    irq_block_a: assert property (wc && !reg_wdata[4] |-> ##2 !cmp_irq_req)
        else $error("request not blocked");
    irq_raise_a: assert property (wc && reg_wdata[5:4] == 2'h3 |-> ##2 cmp_irq_req)
        else $error("request not raised");
    flag_hold_a: assert property (cmp_irq_req && !wc && !$past(wc) |=> cmp_irq_req)
        else $error("request dropped without write");
    cmp_result_a: assert property (reg_rd && reg_addr == OSC_MODE_CONTROL_OFS
        |=> reg_rdata[7] == $past(cmp_in)) else $error("result bit wrong");
    pad_cmp_a: assert property ((wc && reg_wdata[6]) ##1 (!wc && $stable(cmp_in))
        ##1 $stable(cmp_in) |-> port_b_bit3_pad_out == cmp_in && !port_b_bit3_pad_oe_n)
        else $error("pad not driven by comparator");
    reset_vals_a: assert property ($rose(reset_n) |-> sys_osc_high_sel && !high_osc_stop
        && op_mode_sel == 2'h0 && !cmp_irq_req) else $error("reset values wrong");
endmodule
bind omc_osc_mode_ctrl omc_properties chk_i (.*);

// ===== test/osc_opmode_cmp_control_bench.sv
// Purpose: register-level test of the oscillator and mode control unit
// Assumes: outputs settle two edges after a write
// Notes: the port leg is seen after reset and again once comparator and buzzer let go
`timescale 1ns/100ps
module osc_opmode_cmp_control_bench;
    import omc_pkg::*;
    logic mclk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, cmp_in = 0;
    logic buzzer_en = 0, buzzer_out = 0, gpio_out = 1, gpio_out_en_n = 0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0, reg_rdata;
    logic sys_osc_high_sel, high_osc_stop, high_osc_run, mode_halt, mode_standby, cmp_irq_req;
    logic port_b_bit3_pad_out, port_b_bit3_pad_oe_n, irq;
    logic [1:0] op_mode_sel;
    int fails = 0, n_compared = 0;
    omc_osc_mode_ctrl dut (.*);
    always #12.5 mclk = ~mclk;
    task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(logic [4:0] a, logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [4:0] a, logic [7:0] exp);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk("rdata", reg_rdata, exp);
    endtask
    task automatic settle(int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #50000;
        fails++;
        give_verdict;
    end
    initial begin
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        rd(OSC_MODE_CONTROL_OFS, 8'h01);
        chk("reset outs", 8'({sys_osc_high_sel, high_osc_run}), 8'h3);
        // port leg drives the pad while comparator and buzzer are off
        chk("port leg", 8'({port_b_bit3_pad_out, port_b_bit3_pad_oe_n}), 8'h2);
        $display("reset test done");
        // stop never moves in the same write as select or mode
        wr(OSC_MODE_CONTROL_OFS, 8'h00);
        settle(1);
        chk("select low", 8'(sys_osc_high_sel), 8'h0);
        wr(OSC_MODE_CONTROL_OFS, 8'h02);
        settle(1);
        chk("stop", 8'({high_osc_stop, high_osc_run}), 8'h2);
        wr(OSC_MODE_CONTROL_OFS, 8'h00);
        wr(OSC_MODE_CONTROL_OFS, 8'h01);
        settle(1);
        chk("select high", 8'({sys_osc_high_sel, high_osc_run}), 8'h3);
        wr(IRQ_MASK_OFS, 8'h02);
        for (int m = 0; m < 4; m++) begin
            wr(OSC_MODE_CONTROL_OFS, 8'(m * 4 + 1));
            settle(1);
            chk("mode", 8'({op_mode_sel, mode_halt, mode_standby}),
                8'(m * 4 + (m == 1) * 2 + (m == 2)));
        end
        settle(1);
        chk("irq reserved", 8'(irq), 8'h1);
        rd(IRQ_STATUS_OFS, 8'h02);
        wr(IRQ_MASK_OFS, 8'h00);
        settle(1);
        chk("irq cleared", 8'(irq), 8'h0);
        wr(OSC_MODE_CONTROL_OFS, 8'h0d);
        settle(2);
        chk("irq masked", 8'(irq), 8'h0);
        rd(IRQ_STATUS_OFS, 8'h02);
        $display("mode test done");
        wr(OSC_MODE_CONTROL_OFS, 8'h11);
        @(posedge mclk);
        cmp_in <= 1'b1;
        settle(3);
        chk("req on change", 8'(cmp_irq_req), 8'h1);
        rd(OSC_MODE_CONTROL_OFS, 8'hb1);
        settle(5);
        chk("req held", 8'(cmp_irq_req), 8'h1);
        wr(OSC_MODE_CONTROL_OFS, 8'h11);
        rd(OSC_MODE_CONTROL_OFS, 8'h91);
        wr(OSC_MODE_CONTROL_OFS, 8'h21);
        settle(1);
        chk("req gated", 8'(cmp_irq_req), 8'h0);
        rd(OSC_MODE_CONTROL_OFS, 8'ha1);
        // the single comparator edge left its sticky status bit behind
        rd(IRQ_STATUS_OFS, 8'h01);
        $display("comparator test done");
        @(posedge mclk);
        buzzer_en <= 1'b1;
        wr(OSC_MODE_CONTROL_OFS, 8'h71);
        settle(2);
        chk("pad cmp", 8'({port_b_bit3_pad_out, port_b_bit3_pad_oe_n}), 8'h2);
        wr(OSC_MODE_CONTROL_OFS, 8'h01);
        settle(2);
        chk("pad buzzer", 8'(port_b_bit3_pad_out), 8'h0);
        @(posedge mclk);
        buzzer_en <= 1'b0;
        gpio_out_en_n <= 1'b1;
        settle(2);
        chk("pad port", 8'({port_b_bit3_pad_out, port_b_bit3_pad_oe_n}), 8'h3);
        wr(5'h03, 8'hff);
        rd(5'h03, 8'h00);
        $display("pad test done");
        give_verdict;
    end
endmodule
